/* File: eivs_top.sv */
// Notes on behaviour
// - Select bit changes only within four cycles after unlock, unlock written zero.
// - Servicing blocked from unlock until after the instruction following select write.
// - Unlock without select write blocks interrupts for four cycles only.
// - Automatic blocking never alters the global interrupt enable bit.
// - Boot lock bits suppress interrupts in the section not holding vectors.
// - Select zero puts vectors at flash start; one at boot section start.
// - Unlock clears four cycles after written or when select is written.
// - Pins trigger interrupts even when driven as outputs by the port.
// - Group hi fires on enabled pins 15..8, group lo on pins 7..0.
// - Pin-change detection works without clock to wake the part.
// - Low-level mode requests for as long as the pin stays low.
// - Edge detection uses the clock; low-level detection works without it.
// - Level gone before start-up ends gives wake-up but no interrupt.
// - Sense bits: 00 low, 01 any change, 10 falling, 11 rising.
// - Input sampled before edge detection; pulses over one clock are caught.
// - Enable bit 0 with global enable allows dedicated input's own vector.
// - Enable bits 7 and 6 gate groups hi and lo with global enable.
// - Triggers set flag bits 7, 6, 0; vector taken when both enables set.
// - Flags clear on handler entry and when software writes one.
// - Dedicated flag reads zero while low-level sensing is selected.
// - Pin mask bits select pins; cleared bits keep pins out of the group.
`timescale 1ns/100ps
`default_nettype none
module eivs_top
	import eivs_pkg::*;
#(
	parameter int ADDR_W = 14,
	parameter int FLASH_WORDS = 8192,
	parameter int BOOT_MIN_WORDS = 128
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic dedicated_irq_input_in,
	input wire logic [15:0] pin_change_inputs_in,
	input wire logic global_irq_enable_in,
	input wire logic [2:0] irq_ack_in,
	input wire logic instr_done_in,
	input wire logic exec_in_boot_in,
	input wire logic app_side_boot_lock_in,
	input wire logic boot_side_boot_lock_in,
	input wire logic [1:0] boot_size_fuses_in,
	output logic [2:0] irq_req_out,
	output logic irq_blocked_out,
	output logic [ADDR_W-1:0] vector_base_out,
	output logic wake_out
);
	generate
		if (ADDR_W < 2 || ADDR_W > 24 || FLASH_WORDS > (1 << ADDR_W) ||
			BOOT_MIN_WORDS * 8 > FLASH_WORDS) begin : g_bad_params
			$error("eivs_top: address width or section sizes unusable");
		end
	endgenerate

	logic [1:0] sense_reg;
	logic [7:0] mask_lo_reg;
	logic [7:0] mask_hi_reg;
	logic vector_table_select_reg;
	logic vector_change_unlock_reg;
	logic [2:0] unlock_cnt_reg;
	logic post_write_block_reg;
	logic [7:0] enable_reg;
	logic dedicated_irq_flag_reg;
	logic group_lo_flag_reg;
	logic group_hi_flag_reg;
	logic ded_last_reg;

	logic [16:0] pins_sync;
	logic ded_sync;
	logic change_lo;
	logic change_hi;
	logic async_lo;
	logic async_hi;
	logic wr_sense;
	logic wr_vector;
	logic wr_enable;
	logic wr_flags;
	logic level_mode;
	logic ded_edge;
	logic ded_level;
	logic section_suppress;
	logic service_ok;
	logic [ADDR_W-1:0] boot_start;

	assign wr_sense = reg_wr_in && (reg_addr_in == EIVS_OFF_SENSE);
	assign wr_vector = reg_wr_in && (reg_addr_in == EIVS_OFF_VECTOR);
	assign wr_enable = reg_wr_in && (reg_addr_in == EIVS_OFF_ENABLE);
	assign wr_flags = reg_wr_in && (reg_addr_in == EIVS_OFF_FLAGS);

	// Pin levels are read as they stand, whatever the port drives.
	eivs_sync #(
		.WIDTH(17)
	) u_sync (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.async_in({dedicated_irq_input_in, pin_change_inputs_in}),
		.sync_out(pins_sync)
	);

	assign ded_sync = pins_sync[16];

	// Two-stage synchronised pins compared with the previous sample.
	eivs_pin_group #(
		.WIDTH(8)
	) u_group_lo (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.raw_pins_in(pin_change_inputs_in[7:0]),
		.sync_pins_in(pins_sync[7:0]),
		.mask_in(mask_lo_reg),
		.change_out(change_lo),
		.async_change_out(async_lo)
	);

	eivs_pin_group #(
		.WIDTH(8)
	) u_group_hi (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.raw_pins_in(pin_change_inputs_in[15:8]),
		.sync_pins_in(pins_sync[15:8]),
		.mask_in(mask_hi_reg),
		.change_out(change_hi),
		.async_change_out(async_hi)
	);

	// Sense control and pin masks.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sense_reg <= EIVS_RST_SENSE[1:0];
			mask_lo_reg <= EIVS_RST_MASK;
			mask_hi_reg <= EIVS_RST_MASK;
			enable_reg <= EIVS_RST_ENABLE;
		end else begin
			if (wr_sense) begin
				sense_reg <= {reg_wdata_in[EIVS_BIT_SENSE_HI],
					reg_wdata_in[EIVS_BIT_SENSE_LO]};
			end
			if (reg_wr_in && reg_addr_in == EIVS_OFF_MASK_LO) begin
				mask_lo_reg <= reg_wdata_in;
			end
			if (reg_wr_in && reg_addr_in == EIVS_OFF_MASK_HI) begin
				mask_hi_reg <= reg_wdata_in;
			end
			if (wr_enable) begin
				enable_reg <= reg_wdata_in;
			end
		end
	end

	// Protected vector move: unlock, then select within the open window.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			vector_table_select_reg <= EIVS_RST_VECTOR[EIVS_BIT_SELECT];
			vector_change_unlock_reg <= EIVS_RST_VECTOR[EIVS_BIT_UNLOCK];
			unlock_cnt_reg <= 3'h0;
		end else if (wr_vector && reg_wdata_in[EIVS_BIT_UNLOCK]) begin
			vector_change_unlock_reg <= 1'b1;
			unlock_cnt_reg <= EIVS_UNLOCK_CYCLES;
		end else if (wr_vector && vector_change_unlock_reg) begin
			vector_table_select_reg <= reg_wdata_in[EIVS_BIT_SELECT];
			vector_change_unlock_reg <= 1'b0;
			unlock_cnt_reg <= 3'h0;
		end else if (vector_change_unlock_reg) begin
			if (unlock_cnt_reg == 3'h1) begin
				vector_change_unlock_reg <= 1'b0;
			end
			unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
		end
	end

	// After a select write, hold off until the next instruction completes.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			post_write_block_reg <= 1'b0;
		end else if (wr_vector && vector_change_unlock_reg &&
			!reg_wdata_in[EIVS_BIT_UNLOCK]) begin
			post_write_block_reg <= 1'b1;
		end else if (instr_done_in) begin
			post_write_block_reg <= 1'b0;
		end
	end

	// Blocking is its own gate; the global enable input is only read.
	assign irq_blocked_out = vector_change_unlock_reg ||
		post_write_block_reg;

	// Sections locked against the vector table see no interrupts.
	assign section_suppress = (vector_table_select_reg &&
		app_side_boot_lock_in && !exec_in_boot_in) ||
		(!vector_table_select_reg && boot_side_boot_lock_in &&
		exec_in_boot_in);

	assign service_ok = global_irq_enable_in && !irq_blocked_out &&
		!section_suppress;

	// Boot section start: smallest section for fuse code 3.
	always_comb begin
		boot_start = ADDR_W'(FLASH_WORDS -
			(BOOT_MIN_WORDS << (2'h3 - boot_size_fuses_in)));
	end

	assign vector_base_out = vector_table_select_reg ? boot_start :
		'0;

	// Dedicated input: edges on the synchronised level.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ded_last_reg <= 1'b0;
		end else begin
			ded_last_reg <= ded_sync;
		end
	end

	assign level_mode = (sense_reg == EIVS_SENSE_LOW);

	always_comb begin
		case (sense_reg)
			EIVS_SENSE_ANY: ded_edge = ded_sync ^ ded_last_reg;
			EIVS_SENSE_FALL: ded_edge = !ded_sync && ded_last_reg;
			EIVS_SENSE_RISE: ded_edge = ded_sync && !ded_last_reg;
			default: ded_edge = 1'b0;
		endcase
	end

	// The level request follows the pin and latches nothing, so a level
	// that vanishes during start-up leaves no request behind.
	assign ded_level = level_mode && !ded_sync;

	// Flags: a hardware set wins over a same-cycle clear.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			dedicated_irq_flag_reg <= EIVS_RST_FLAGS[EIVS_BIT_DED];
		end else if (level_mode) begin
			dedicated_irq_flag_reg <= 1'b0;
		end else if (ded_edge) begin
			dedicated_irq_flag_reg <= 1'b1;
		end else if (irq_ack_in[EIVS_REQ_DED] ||
			(wr_flags && reg_wdata_in[EIVS_BIT_DED])) begin
			dedicated_irq_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			group_lo_flag_reg <= EIVS_RST_FLAGS[EIVS_BIT_GRP_LO];
		end else if (change_lo) begin
			group_lo_flag_reg <= 1'b1;
		end else if (irq_ack_in[EIVS_REQ_LO] ||
			(wr_flags && reg_wdata_in[EIVS_BIT_GRP_LO])) begin
			group_lo_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			group_hi_flag_reg <= EIVS_RST_FLAGS[EIVS_BIT_GRP_HI];
		end else if (change_hi) begin
			group_hi_flag_reg <= 1'b1;
		end else if (irq_ack_in[EIVS_REQ_HI] ||
			(wr_flags && reg_wdata_in[EIVS_BIT_GRP_HI])) begin
			group_hi_flag_reg <= 1'b0;
		end
	end

	// Requests, one per vector, gated by own and global enables.
	assign irq_req_out[EIVS_REQ_DED] = service_ok &&
		enable_reg[EIVS_BIT_DED] &&
		(dedicated_irq_flag_reg || ded_level);
	assign irq_req_out[EIVS_REQ_LO] = service_ok &&
		enable_reg[EIVS_BIT_GRP_LO] && group_lo_flag_reg;
	assign irq_req_out[EIVS_REQ_HI] = service_ok &&
		enable_reg[EIVS_BIT_GRP_HI] && group_hi_flag_reg;

	// Wake-up paths that need no clock edge.
	assign wake_out = (enable_reg[EIVS_BIT_GRP_LO] && async_lo) ||
		(enable_reg[EIVS_BIT_GRP_HI] && async_hi) ||
		(enable_reg[EIVS_BIT_DED] && level_mode &&
		!dedicated_irq_input_in);

	// Registered read port; unmapped addresses read zero.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				EIVS_OFF_SENSE: reg_rdata_out <= {6'h00, sense_reg};
				EIVS_OFF_MASK_LO: reg_rdata_out <= mask_lo_reg;
				EIVS_OFF_MASK_HI: reg_rdata_out <= mask_hi_reg;
				EIVS_OFF_VECTOR: reg_rdata_out <= {6'h00,
					vector_table_select_reg, vector_change_unlock_reg};
				EIVS_OFF_ENABLE: reg_rdata_out <= {enable_reg[7:6], 5'h00,
					enable_reg[0]};
				EIVS_OFF_FLAGS: reg_rdata_out <= {group_hi_flag_reg,
					group_lo_flag_reg, 5'h00, dedicated_irq_flag_reg};
				default: reg_rdata_out <= 8'h00;
			endcase
		end
	end
endmodule : eivs_top
`default_nettype wire

/* File: eivs_pkg.sv */
package eivs_pkg;

	// Register offsets on the data-space register port.
	localparam logic [7:0] EIVS_OFF_SENSE = 8'h69;
	localparam logic [7:0] EIVS_OFF_MASK_LO = 8'h6B;
	localparam logic [7:0] EIVS_OFF_MASK_HI = 8'h73;
	localparam logic [7:0] EIVS_OFF_VECTOR = 8'h70;
	localparam logic [7:0] EIVS_OFF_ENABLE = 8'h71;
	localparam logic [7:0] EIVS_OFF_FLAGS = 8'h72;

	// Field positions.
	localparam int EIVS_BIT_SENSE_LO = 0;
	localparam int EIVS_BIT_SENSE_HI = 1;
	localparam int EIVS_BIT_UNLOCK = 0;
	localparam int EIVS_BIT_SELECT = 1;
	localparam int EIVS_BIT_DED = 0;
	localparam int EIVS_BIT_GRP_LO = 6;
	localparam int EIVS_BIT_GRP_HI = 7;

	// Reset values.
	localparam logic [7:0] EIVS_RST_SENSE = 8'h00;
	localparam logic [7:0] EIVS_RST_MASK = 8'h00;
	localparam logic [7:0] EIVS_RST_VECTOR = 8'h00;
	localparam logic [7:0] EIVS_RST_ENABLE = 8'h00;
	localparam logic [7:0] EIVS_RST_FLAGS = 8'h00;

	// Sense control encodings.
	localparam logic [1:0] EIVS_SENSE_LOW = 2'h0;
	localparam logic [1:0] EIVS_SENSE_ANY = 2'h1;
	localparam logic [1:0] EIVS_SENSE_FALL = 2'h2;
	localparam logic [1:0] EIVS_SENSE_RISE = 2'h3;

	// Timing: cycles the unlock bit stays open.
	localparam logic [2:0] EIVS_UNLOCK_CYCLES = 3'h4;

	// Request vector indices.
	localparam int EIVS_REQ_DED = 0;
	localparam int EIVS_REQ_LO = 1;
	localparam int EIVS_REQ_HI = 2;

endpackage : eivs_pkg

/* File: eivs_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module eivs_sync #(
	parameter int WIDTH = 17
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("eivs_sync: width must be at least one");
		end
	endgenerate

	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stage1_reg <= '0;
			sync_out <= '0;
		end else begin
			stage1_reg <= async_in;
			sync_out <= stage1_reg;
		end
	end
endmodule : eivs_sync
`default_nettype wire

/* File: eivs_pin_group.sv */
`timescale 1ns/100ps
`default_nettype none
module eivs_pin_group #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic [WIDTH-1:0] raw_pins_in,
	input wire logic [WIDTH-1:0] sync_pins_in,
	input wire logic [WIDTH-1:0] mask_in,
	output logic change_out,
	output logic async_change_out
);
	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("eivs_pin_group: width must be at least one");
		end
	endgenerate

	logic [WIDTH-1:0] last_reg;

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			last_reg <= '0;
		end else begin
			last_reg <= sync_pins_in;
		end
	end

	// Clocked detection compares the synchronised pins with their last value.
	assign change_out = |((sync_pins_in ^ last_reg) & mask_in);
	// The held value stays put while the clock is stopped, so a raw pin
	// that moves away from it is seen without any clock edge.
	assign async_change_out = |((raw_pins_in ^ last_reg) & mask_in);
endmodule : eivs_pin_group
`default_nettype wire

/* File: eivs_top_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module eivs_top_checker
	import eivs_pkg::*;
#(
	parameter int ADDR_W = 14,
	parameter int FLASH_WORDS = 8192,
	parameter int BOOT_MIN_WORDS = 128
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [2:0] irq_ack_in,
	input wire logic instr_done_in,
	input wire logic exec_in_boot_in,
	input wire logic app_side_boot_lock_in,
	input wire logic boot_side_boot_lock_in,
	input wire logic [1:0] boot_size_fuses_in,
	input wire logic [15:0] pin_change_inputs_in,
	input wire logic [2:0] irq_req_out,
	input wire logic irq_blocked_out,
	input wire logic [ADDR_W-1:0] vector_base_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	logic wr_vec;
	logic wr_unl;
	logic wr_sel;
	logic lock_on;
	logic [1:0] quiet_reg;
	logic [ADDR_W-1:0] boot_start;
	assign wr_vec = reg_wr_in && reg_addr_in == EIVS_OFF_VECTOR;
	assign wr_unl = wr_vec && reg_wdata_in[EIVS_BIT_UNLOCK];
	assign wr_sel = wr_vec && !reg_wdata_in[EIVS_BIT_UNLOCK];
	assign boot_start = ADDR_W'(FLASH_WORDS -
		(BOOT_MIN_WORDS << (3 - boot_size_fuses_in)));
	assign lock_on = (app_side_boot_lock_in && !exec_in_boot_in &&
		vector_base_out != '0) || (boot_side_boot_lock_in &&
		exec_in_boot_in && vector_base_out == '0);
	// Counts quiet cycles on the pins so an ack is judged only when no
	// change is still travelling through the synchroniser.
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			quiet_reg <= 2'h0;
		else if ($changed(pin_change_inputs_in))
			quiet_reg <= 2'h0;
		else if (quiet_reg != 2'h3)
			quiet_reg <= quiet_reg + 2'h1;
	end
	property p_unlock_blocks;
		wr_unl |=> irq_blocked_out;
	endproperty
	a_unlock_blocks: assert property (p_unlock_blocks) else $error("no block");
	property p_unlock_hold;
		wr_unl ##1 !wr_vec[*4] |-> irq_blocked_out ##1 !irq_blocked_out;
	endproperty
	a_unlock_hold: assert property (p_unlock_hold) else $error("window");
	property p_select_hold;
		wr_unl ##[1:4] wr_sel |=> irq_blocked_out until instr_done_in;
	endproperty
	a_select_hold: assert property (p_select_hold) else $error("early");
	property p_block_quiet;
		irq_blocked_out |-> irq_req_out == 3'h0;
	endproperty
	a_block_quiet: assert property (p_block_quiet) else $error("req");
	property p_vec_legal;
		vector_base_out == '0 || vector_base_out == boot_start;
	endproperty
	a_vec_legal: assert property (p_vec_legal) else $error("base");
	property p_vec_change;
		$changed(vector_base_out) && $stable(boot_size_fuses_in) |-> $past(wr_sel);
	endproperty
	a_vec_change: assert property (p_vec_change) else $error("move");
	property p_lock;
		lock_on |-> irq_req_out == 3'h0;
	endproperty
	a_lock: assert property (p_lock) else $error("lock");
	property p_ack_clear;
		(|irq_ack_in[2:1]) && quiet_reg == 2'h3 && $stable(pin_change_inputs_in)
			|=> (irq_req_out[2:1] & $past(irq_ack_in[2:1])) == 2'h0;
	endproperty
	a_ack_clear: assert property (p_ack_clear) else $error("ack");
endmodule : eivs_top_checker
bind eivs_top eivs_top_checker #(.ADDR_W(ADDR_W), .FLASH_WORDS(FLASH_WORDS),
	.BOOT_MIN_WORDS(BOOT_MIN_WORDS)) eivs_top_checker_i (.sys_clk_in,
	.rstn_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .irq_ack_in,
	.instr_done_in, .exec_in_boot_in, .app_side_boot_lock_in,
	.boot_side_boot_lock_in, .boot_size_fuses_in, .pin_change_inputs_in,
	.irq_req_out, .irq_blocked_out, .vector_base_out);
`default_nettype wire

/* File: eivs_pin_source.sv */
`timescale 1ns/100ps
`default_nettype none
module eivs_pin_source (
	input wire logic ded_cmd_in,
	input wire logic [15:0] pins_cmd_in,
	output logic ded_pin_out,
	output logic [15:0] pins_pin_out
);
	// The source drives the lines like a port pin set as output.
	assign ded_pin_out = ded_cmd_in;
	assign pins_pin_out = pins_cmd_in;
endmodule : eivs_pin_source
`default_nettype wire

/* File: eivs_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module eivs_top_tb
	import eivs_pkg::*;
;
	logic sys_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic reg_wr_in = 1'b0;
	logic reg_rd_in = 1'b0;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [7:0] reg_rdata_out;
	logic ded_cmd = 1'b1;
	logic [15:0] pins_cmd = 16'h0000;
	logic ded_pin;
	logic [15:0] pins_pin;
	logic gie = 1'b1;
	logic [2:0] irq_ack_in = 3'h0;
	logic instr_done_in = 1'b0;
	logic in_boot = 1'b0;
	logic app_lock = 1'b0;
	logic boot_lock = 1'b0;
	logic [1:0] fuses = 2'h2;
	logic [2:0] irq_req_out;
	logic irq_blocked_out;
	logic [13:0] vector_base_out;
	logic wake_out;
	logic [7:0] mlo, mhi, en, e;
	int errors = 0;
	int tests_run = 0;
	int seed = 32;
	int cycles = 0;
	int k;
	eivs_pin_source eivs_pin_source_i (.ded_cmd_in(ded_cmd),
		.pins_cmd_in(pins_cmd), .ded_pin_out(ded_pin), .pins_pin_out(pins_pin));
	eivs_top eivs_top_i (.sys_clk_in, .rstn_in, .reg_addr_in, .reg_wr_in,
		.reg_rd_in, .reg_wdata_in, .reg_rdata_out,
		.dedicated_irq_input_in(ded_pin), .pin_change_inputs_in(pins_pin),
		.global_irq_enable_in(gie), .irq_ack_in, .instr_done_in,
		.exec_in_boot_in(in_boot), .app_side_boot_lock_in(app_lock),
		.boot_side_boot_lock_in(boot_lock), .boot_size_fuses_in(fuses),
		.irq_req_out, .irq_blocked_out, .vector_base_out, .wake_out);
	always #12.5 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end
	task automatic results();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		tests_run++;
		if (g !== x) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, x);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		tick(1);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		tick(1);
		reg_wr_in = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		tick(1);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		tick(1);
		reg_rd_in = 1'b0;
		chk(16'(reg_rdata_out), 16'(x));
	endtask : rd
	function automatic logic [7:0] flags_of(int p, logic [15:0] m);
		return {m[p] && p > 7, m[p] && p < 8, 6'h00};
	endfunction : flags_of
	function automatic logic [13:0] boot_start(logic [1:0] f);
		return 14'(8192 - (128 << (3 - f)));
	endfunction : boot_start
	initial begin
		tick(2);
		rstn_in = 1'b1;
		rd(8'h6A, 8'h00);
		rd(EIVS_OFF_VECTOR, EIVS_RST_VECTOR);
		rd(EIVS_OFF_FLAGS, EIVS_RST_FLAGS);
		wr(EIVS_OFF_SENSE, 8'hFF);
		rd(EIVS_OFF_SENSE, 8'h03);
		wr(EIVS_OFF_ENABLE, 8'hFF);
		rd(EIVS_OFF_ENABLE, 8'hC1);
		wr(EIVS_OFF_ENABLE, 8'h01);
		for (int m = 0; m < 4; m++) begin
			wr(EIVS_OFF_SENSE, 8'(m));
			wr(EIVS_OFF_FLAGS, 8'hFF);
			ded_cmd = 1'b0;
			tick(3);
			chk(16'(irq_req_out[0]), 16'(m != 3));
			chk(16'(wake_out), 16'(m == 0));
			ded_cmd = 1'b1;
			tick(4);
			chk(16'(irq_req_out[0]), 16'(m != 0));
			rd(EIVS_OFF_FLAGS, 8'(m != 0));
			irq_ack_in = 3'h1;
			tick(1);
			irq_ack_in = 3'h0;
			tick(1);
			chk(16'(irq_req_out[0]), 16'h0);
		end
		for (int i = 0; i < 16; i++) begin
			k = {$random(seed)} % 16;
			mlo = 8'($random(seed));
			mhi = 8'($random(seed));
			if (i[2])
				{mhi, mlo} = {mhi, mlo} | (16'h1 << k);
			en = i[0] ? 8'hC0 : 8'h00;
			gie = i[1];
			wr(EIVS_OFF_MASK_LO, mlo);
			wr(EIVS_OFF_MASK_HI, mhi);
			wr(EIVS_OFF_ENABLE, en);
			wr(EIVS_OFF_FLAGS, 8'hFF);
			e = flags_of(k, {mhi, mlo});
			pins_cmd[k] = ~pins_cmd[k];
			tick(1);
			chk(16'(wake_out), 16'(|(e[7:6] & en[7:6])));
			tick(3);
			rd(EIVS_OFF_FLAGS, e);
			chk(16'(irq_req_out), 16'({e[7:6] & en[7:6] & {2{gie}}, 1'b0}));
			chk(16'(wake_out), 16'h0);
			rd(EIVS_OFF_MASK_HI, mhi);
			if (i[0]) begin
				irq_ack_in = 3'h6;
				tick(1);
				irq_ack_in = 3'h0;
			end else
				wr(EIVS_OFF_FLAGS, 8'hC0);
			rd(EIVS_OFF_FLAGS, 8'h00);
		end
		gie = 1'b1;
		wr(EIVS_OFF_VECTOR, 8'h02);
		chk(16'(vector_base_out), 16'h0);
		wr(EIVS_OFF_VECTOR, 8'h01);
		chk(16'(irq_blocked_out), 16'h1);
		tick(4);
		chk(16'(irq_blocked_out), 16'h0);
		rd(EIVS_OFF_VECTOR, 8'h00);
		wr(EIVS_OFF_VECTOR, 8'h01);
		wr(EIVS_OFF_VECTOR, 8'h02);
		tick(2);
		chk(16'(irq_blocked_out), 16'h1);
		instr_done_in = 1'b1;
		tick(1);
		instr_done_in = 1'b0;
		chk(16'(irq_blocked_out), 16'h0);
		rd(EIVS_OFF_VECTOR, 8'h02);
		for (int f = 0; f < 4; f++) begin
			fuses = 2'(f);
			tick(1);
			chk(16'(vector_base_out), 16'(boot_start(fuses)));
		end
		wr(EIVS_OFF_MASK_LO, 8'h01);
		wr(EIVS_OFF_ENABLE, 8'h40);
		pins_cmd[0] = ~pins_cmd[0];
		app_lock = 1'b1;
		tick(4);
		chk(16'(irq_req_out), 16'h0);
		in_boot = 1'b1;
		tick(1);
		chk(16'(irq_req_out), 16'h2);
		wr(EIVS_OFF_VECTOR, 8'h01);
		wr(EIVS_OFF_VECTOR, 8'h00);
		instr_done_in = 1'b1;
		boot_lock = 1'b1;
		tick(1);
		instr_done_in = 1'b0;
		chk(16'(irq_req_out), 16'h0);
		in_boot = 1'b0;
		tick(1);
		chk(16'(irq_req_out), 16'h2);
		results();
	end
endmodule : eivs_top_tb
`default_nettype wire
